/* rtl/rhs_pkg.sv */
// Shared constants and carrier types for the reference holdover selector.
package rhs_pkg;

  localparam int unsigned SRC_W         = 2;
  localparam int unsigned HOLDOFF_W     = 8;
  localparam int unsigned DIVIDER_W     = 20;
  localparam int unsigned VALCNT_W      = 8;
  localparam int unsigned FREQ_W        = 24;

  localparam logic [1:0]  MODE_SHORT    = 2'h2;
  localparam logic [1:0]  MODE_AUTO_HO  = 2'h3;

  localparam logic        SEL_RST       = 1'h0;
  localparam logic [HOLDOFF_W-1:0] HOLDOFF_RST = 8'h00;
  localparam logic [DIVIDER_W-1:0] DIV_RST     = 20'h00000;
  localparam logic [VALCNT_W-1:0]  VAL_RST     = 8'h00;
  localparam logic [FREQ_W-1:0]    FREQ_RST    = 24'h000000;

  typedef struct packed {
    logic                 holdover_enable_n;
    logic                 switch_mode_hi_n;
    logic                 switch_mode_lo_n;
    logic                 pin_input_choice;
    logic [VALCNT_W-1:0]  revalidation_count;
    logic [HOLDOFF_W-1:0] holdoff_start_value;
    logic [DIVIDER_W-1:0] holdoff_divider;
  } rhs_cfg_t;

  typedef struct packed {
    logic [SRC_W-1:0] input_signal_state;
    logic             holdover_state_n;
    logic             chosen_input_state;
    logic             reference_valid_state;
  } rhs_status_t;

endpackage

/* rtl/rhs_holdoff.sv */
// Hold-off prescaler and down-counter with automatic reload.
`timescale 1ns/1ps
module rhs_holdoff #(
  parameter int unsigned DW = rhs_pkg::DIVIDER_W,
  parameter int unsigned HW = rhs_pkg::HOLDOFF_W
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          run,
  input  wire logic          start,
  input  wire logic [DW-1:0] divider,
  input  wire logic [HW-1:0] start_value,
  output logic               expire
);

  logic [DW-1:0] pre_q;
  logic [DW-1:0] pre_d;
  logic [HW-1:0] cnt_q;
  logic [HW-1:0] cnt_d;
  logic          tick;

  always_comb begin
    pre_d  = pre_q;
    cnt_d  = cnt_q;
    tick   = 1'b0;
    expire = 1'b0;
    if (start) begin
      pre_d = '0;
      cnt_d = start_value;
      expire = (start_value == '0);
    end else if (run) begin // RULE_15
      if (pre_q + 1'b1 >= divider || divider == '0) begin // RULE_14
        pre_d = '0;
        tick  = 1'b1;
      end else begin
        pre_d = pre_q + 1'b1;
      end
      if (tick) begin
        if (cnt_q <= HW'(1)) begin
          expire = 1'b1;
          cnt_d  = start_value; // RULE_14
        end else begin
          cnt_d = cnt_q - 1'b1; // RULE_09
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= rhs_pkg::DIV_RST;
      cnt_q <= rhs_pkg::HOLDOFF_RST;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

/* rtl/rhs_top.sv */
// Reference selection and holdover control for two redundant inputs.
// Overview of operation
// (RULE_01) In short-term holdover mode the reference is the user choice.
// (RULE_02) In short-term mode a loss on the chosen input enters holdover now.
// (RULE_03) In short-term mode revalidation uses the count, then holdover ends.
// (RULE_04) Each input status flag shows loss while that input is invalid.
// (RULE_05) The active-low holdover flag is low exactly while in holdover.
// (RULE_06) In automatic-with-holdover mode the state machine picks the input.
// (RULE_07) There, a loss or a user change enters holdover and loads hold-off.
// (RULE_08) At hold-off expiry the device fails over to a valid other input.
// (RULE_09) Holdover lasts start value times divider ratio clock periods.
// (RULE_10) Holdover ends early on revalidation or a new user selection.
// (RULE_11) If the other input is invalid at expiry, holdover continues.
// (RULE_12) The chosen-input flag changes only when the switch happens.
// (RULE_13) In holdover the output uses a stored frequency value.
// (RULE_14) The hold-off counter runs off the divided clock and reloads.
// (RULE_15) The divider only runs after a loss or switch in holdover modes.
// (RULE_16) In short-term mode the hold-off counter stays idle.
`timescale 1ns/1ps
module rhs_top #(
  parameter int unsigned VW = rhs_pkg::VALCNT_W,
  parameter int unsigned FW = rhs_pkg::FREQ_W
) (
  input  wire logic                 CORE_CLK,
  input  wire logic                 RESET,
  input  wire rhs_pkg::rhs_cfg_t    CFG,
  input  wire logic [1:0]           INPUT_LOS,
  input  wire logic [FW-1:0]        TRACK_WORD,
  output rhs_pkg::rhs_status_t      STATUS,
  output logic                      ACTIVE_INPUT,
  output logic [FW-1:0]             CONTROL_WORD
);

  // Idle stands for the modes that this block does not hold over in.
  typedef enum logic [1:0] {
    RHS_TRACK,
    RHS_HOLD,
    RHS_IDLE
  } rhs_state_t;

  rhs_state_t         st_q;
  rhs_state_t         st_d;
  logic               act_q;
  logic               act_d;
  logic               usr_q;
  logic [1:0]         valid_q;
  logic [1:0]         valid_d;
  logic [1:0][VW-1:0] vcnt_q;
  logic [1:0][VW-1:0] vcnt_d;
  logic [FW-1:0]      hold_q;
  logic [FW-1:0]      hold_d;
  logic [FW-1:0]      ctl_q;
  logic [FW-1:0]      ctl_d;
  logic               loss_q;
  logic               loss_d;
  logic               tgt;
  logic [1:0]         mode_pins;
  logic               short_mode;
  logic               auto_mode;
  logic               user_change;
  logic               ho_start;
  logic               ho_run;
  logic               expire;

  // The mode pins are compared as they stand at the pins: the enable pin
  // high with the mode pair at high-low is short-term holdover, and with
  // the pair at high-high it is the automatic mode with holdover.
  assign mode_pins   = {CFG.switch_mode_hi_n, CFG.switch_mode_lo_n};
  assign short_mode  = CFG.holdover_enable_n &&
                       (mode_pins == rhs_pkg::MODE_SHORT);
  assign auto_mode   = CFG.holdover_enable_n &&
                       (mode_pins == rhs_pkg::MODE_AUTO_HO);

  // A user change is seen as a difference from the choice of the cycle
  // before, so it lasts one cycle however long the new level stands.
  assign user_change = CFG.pin_input_choice != usr_q;

  // Each input must stay clean for the count before it counts as valid.
  // A loss drops the flag at once, while return takes one cycle more than
  // the count, so a chattering input does not bounce the selection.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_val
      always_comb begin
        vcnt_d[g]  = vcnt_q[g];
        valid_d[g] = valid_q[g];
        if (INPUT_LOS[g]) begin
          vcnt_d[g]  = '0;
          valid_d[g] = 1'b0;
        end else if (!valid_q[g]) begin
          if (vcnt_q[g] >= CFG.revalidation_count) begin // RULE_03
            valid_d[g] = 1'b1;
          end else begin
            vcnt_d[g] = vcnt_q[g] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // Holdover in the automatic mode has two causes. After a loss the
  // original input may come back and end it; after a user change the
  // original input is still good, so only the countdown, a further change,
  // or its loss and return may end it. The loss flag keeps the two cases apart.
  always_comb begin
    st_d     = st_q;
    act_d    = act_q;
    loss_d   = loss_q;
    tgt      = loss_q ? !act_q : CFG.pin_input_choice;
    ho_start = 1'b0;
    ho_run   = 1'b0;
    if (short_mode) begin
      act_d  = CFG.pin_input_choice; // RULE_01
      loss_d = 1'b1;
      if (!valid_d[act_d]) begin
        st_d = RHS_HOLD; // RULE_02
      end else begin
        st_d = RHS_TRACK; // RULE_03
      end
    end else if (auto_mode) begin
      unique case (st_q)
        RHS_TRACK, RHS_IDLE: begin
          if (!valid_q[act_q]) begin
            st_d     = RHS_HOLD; // RULE_07
            loss_d   = 1'b1;
            ho_start = 1'b1;
          end else if (user_change) begin
            st_d     = RHS_HOLD; // RULE_07
            loss_d   = 1'b0;
            ho_start = 1'b1;
          end
        end
        RHS_HOLD: begin
          ho_run = 1'b1; // RULE_15
          loss_d = loss_q || !valid_q[act_q];
          if (user_change) begin
            act_d = CFG.pin_input_choice; // RULE_10
            st_d  = RHS_TRACK;
          end else if (loss_q && valid_q[act_q]) begin
            st_d = RHS_TRACK; // RULE_10
          end else if (expire && valid_q[tgt]) begin
            act_d = tgt; // RULE_08
            st_d  = RHS_TRACK;
          end else begin
            // With no valid target the counter reloads and tries again.
            st_d = RHS_HOLD; // RULE_11
          end
        end
      endcase
    end else begin
      // Modes outside this block just follow the user choice.
      act_d  = CFG.pin_input_choice;
      loss_d = 1'b1;
      st_d   = RHS_IDLE;
    end
  end

  // The word is frozen from the control word of the cycle before entry,
  // so the loop keeps one steady value for the whole of holdover.
  always_comb begin
    hold_d = hold_q;
    ctl_d  = TRACK_WORD;
    if (st_d == RHS_HOLD) begin
      if (st_q != RHS_HOLD) begin
        hold_d = ctl_q;
      end
      ctl_d = hold_d; // RULE_13
    end
  end

  // Out of reset no input is trusted yet, so in the holdover modes the active
  // input must pass validation before the loop can track it.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_q    <= RHS_IDLE;
      act_q   <= rhs_pkg::SEL_RST;
      loss_q  <= 1'b0;
      usr_q   <= rhs_pkg::SEL_RST;
      valid_q <= 2'h0;
      vcnt_q  <= '0;
      hold_q  <= rhs_pkg::FREQ_RST;
      ctl_q   <= rhs_pkg::FREQ_RST;
    end else begin
      st_q    <= st_d;
      act_q   <= act_d;
      loss_q  <= loss_d;
      usr_q   <= CFG.pin_input_choice;
      valid_q <= valid_d;
      vcnt_q  <= vcnt_d;
      hold_q  <= hold_d;
      ctl_q   <= ctl_d;
    end
  end

  // Short-term mode neither starts nor runs the counter, and a start that
  // meets a running count restarts it from the start value.
  rhs_holdoff u_holdoff (
    .clk         (CORE_CLK),
    .rst         (RESET),
    .run         (ho_run), // RULE_16
    .start       (ho_start),
    .divider     (CFG.holdoff_divider),
    .start_value (CFG.holdoff_start_value),
    .expire      (expire)
  );

  // The reference flag follows the active input, so after a failover it
  // shows the state of the new input at once.
  always_comb begin
    STATUS.input_signal_state    = valid_q; // RULE_04
    STATUS.holdover_state_n      = (st_q != RHS_HOLD); // RULE_05
    STATUS.chosen_input_state    = act_q; // RULE_12
    STATUS.reference_valid_state = valid_q[act_q];
  end

  assign ACTIVE_INPUT = act_q; // RULE_06
  assign CONTROL_WORD = ctl_q;

endmodule

/* bench/rhs_src_model.sv */
// Two reference sources that drop on demand, plus a moving loop word.
`timescale 1ns/1ps
module rhs_src_model #(
  parameter int unsigned FW = 24
) (
  input  wire logic          clk,
  input  wire logic [1:0]    kill,
  output logic [1:0]         los,
  output logic [FW-1:0]      track
);
  initial track = '0;
  assign los = kill;
  // The word changes every cycle so that a frozen output is visible.
  always @(posedge clk) track <= track + 1'h1;
endmodule

/* bench/rhs_top_asserts.sv */
// Port-level checks for the reference holdover selector.
`timescale 1ns/1ps
module rhs_top_asserts #(
  parameter int unsigned VW = 8,
  parameter int unsigned FW = 24
) (
  input wire logic                 CORE_CLK,
  input wire logic                 RESET,
  input wire rhs_pkg::rhs_cfg_t    CFG,
  input wire logic [1:0]           INPUT_LOS,
  input wire logic [FW-1:0]        TRACK_WORD,
  input wire rhs_pkg::rhs_status_t STATUS,
  input wire logic                 ACTIVE_INPUT,
  input wire logic [FW-1:0]        CONTROL_WORD
);
  logic       sh;
  logic       au;
  logic       ho;
  logic       ok;
  logic [1:0] md;
  logic       ch;
  assign md = {CFG.switch_mode_hi_n, CFG.switch_mode_lo_n};
  assign sh = CFG.holdover_enable_n && md == rhs_pkg::MODE_SHORT;
  assign au = CFG.holdover_enable_n && md == rhs_pkg::MODE_AUTO_HO;
  assign ho = !STATUS.holdover_state_n;
  assign ok = STATUS.input_signal_state[ACTIVE_INPUT];
  assign ch = CFG.pin_input_choice;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  sequence s_lost;
    INPUT_LOS[0] [*2];
  endsequence
  AST_SHORT_SEL: assert property ((sh && !$past(RESET) && $stable(ch)) [*3]
    |-> ACTIVE_INPUT == ch) else $error("active input not the choice");
  AST_SHORT_HOLD: assert property (sh && $fell(ok) |-> ##[0:1] ho)
    else $error("no holdover on loss");
  AST_LOS_FLAG: assert property (s_lost |-> !STATUS.input_signal_state[0])
    else $error("lost input shown valid");
  AST_FROZEN: assert property (ho && $past(ho) |-> $stable(CONTROL_WORD))
    else $error("control word moved in holdover");
  AST_SWITCH: assert property (au && $past(au) && $changed(ACTIVE_INPUT)
    |-> $past(ho)) else $error("switch outside holdover");
  AST_NO_VALID: assert property (au && ho && STATUS.input_signal_state == 2'h0
    && $stable(CFG) |=> ho) else $error("holdover left with no input");
  AST_USER_CHG: assert property (au && $past(au) && !ho && $changed(ch)
    && ch != ACTIVE_INPUT |-> ##[0:2] ho) else $error("no holdover on change");
  AST_SEL_FLAG: assert property (au && $past(au)
    && $changed(STATUS.chosen_input_state) |-> !ho)
    else $error("chosen flag moved without ending holdover");
endmodule

/* bench/tb.sv */
// Self-checking bench for the reference holdover selector.
`timescale 1ns/1ps
`define CHK(s, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", s, e, g); end end
module tb;
  logic                         clk;
  logic                         rst;
  logic [1:0]                   kill;
  logic [1:0]                   los;
  logic [rhs_pkg::FREQ_W-1:0]   track;
  logic [rhs_pkg::FREQ_W-1:0]   ctl;
  logic [rhs_pkg::FREQ_W-1:0]   w;
  logic                         act;
  rhs_pkg::rhs_cfg_t            cfg;
  rhs_pkg::rhs_status_t         st;
  int                           bad_count;
  int                           tests_run;
  int                           cyc;
  int                           n;
  rhs_src_model src_i (.clk(clk), .kill(kill), .los(los), .track(track));
  rhs_top rhs_top_i (.CORE_CLK(clk), .RESET(rst), .CFG(cfg), .INPUT_LOS(los),
    .TRACK_WORD(track), .STATUS(st), .ACTIVE_INPUT(act), .CONTROL_WORD(ctl));
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic pick(logic lo_n, logic c);
    @(negedge clk);
    cfg.switch_mode_lo_n = lo_n;
    cfg.pin_input_choice = c;
  endtask
  task automatic lose(logic [1:0] k, int s);
    @(negedge clk);
    kill = k;
    repeat (s) @(negedge clk);
  endtask
  // Counts cycles until the holdover flag reaches v, bounded at 200.
  task automatic wait_hold(logic v);
    n = 0;
    while (st.holdover_state_n !== v && n < 200) begin
      @(negedge clk);
      n++;
    end
    `CHK("wait", 1'h1, n < 200)
  endtask
  initial begin
    rst = 1'h1;
    kill = 2'h0;
    cfg = '{1'h1, 1'h1, 1'h0, 1'h0, 8'h03, 8'h04, 20'h00002};
    lose(2'h0, 9);
    rst = 1'h0;
    lose(2'h0, 12);
    `CHK("valid", 2'h3, st.input_signal_state)
    pick(1'h0, 1'h1);
    lose(2'h2, 0);
    `CHK("active", 1'h1, act)
    wait_hold(1'h0);
    `CHK("cycles", 1'h1, n <= 3)
    `CHK("valid", 2'h1, st.input_signal_state)
    w = ctl;
    lose(2'h2, 30);
    `CHK("control", w, ctl)
    `CHK("hold", 1'h0, st.holdover_state_n)
    lose(2'h0, 0);
    wait_hold(1'h1);
    `CHK("cycles", 1'h1, n >= 4 && n <= 7)
    `CHK("active", 1'h1, act)
    pick(1'h1, 1'h1);
    pick(1'h1, 1'h0);
    wait_hold(1'h0);
    `CHK("cycles", 1'h1, n <= 3)
    pick(1'h1, 1'h1);
    wait_hold(1'h1);
    `CHK("cycles", 1'h1, n <= 3)
    `CHK("active", 1'h1, act)
    lose(2'h2, 0);
    wait_hold(1'h0);
    lose(2'h2, 4);
    `CHK("active", 1'h1, act)
    wait_hold(1'h1);
    `CHK("cycles", 1'h1, n == 3)
    `CHK("active", 1'h0, act)
    `CHK("chosen", 1'h0, st.chosen_input_state)
    lose(2'h3, 0);
    wait_hold(1'h0);
    lose(2'h3, 40);
    `CHK("hold", 1'h0, st.holdover_state_n)
    lose(2'h2, 0);
    wait_hold(1'h1);
    `CHK("active", 1'h0, act)
    `CHK("tracking", 1'h1, ctl !== w)
    complete_run();
  end
endmodule
bind rhs_top rhs_top_asserts #(.VW(VW), .FW(FW)) chk_i (.CORE_CLK(CORE_CLK),
  .RESET(RESET), .CFG(CFG), .INPUT_LOS(INPUT_LOS), .TRACK_WORD(TRACK_WORD),
  .STATUS(STATUS), .ACTIVE_INPUT(ACTIVE_INPUT), .CONTROL_WORD(CONTROL_WORD));
